// [bench/tb_dcpm_power_ctrl.sv]
// Self-checking bench for the dual clock power-mode controller.
// Assumes assertions live in the core; inputs change on falling edges.
`default_nettype none
module tb_dcpm_power_ctrl;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        portg_wr = 1'b0;
  logic [7:0]  portg_data = 8'h00;
  logic        halt_dis = 1'b0;
  logic        wakeup = 1'b0;
  logic        slow_tick = 1'b0;
  logic        dly_bit = 1'b0;
  logic        ck_sel = 1'b0;
  logic        fast_en = 1'b1;
  logic        slow_en = 1'b0;
  logic        dual_en = 1'b0;
  logic        win_wr = 1'b0;
  logic [2:0]  win_fld = 3'h0;
  logic        irq_en = 1'b0;
  logic        pnd_clr = 1'b0;
  logic [1:0]  mode;
  logic        halted;
  logic        idle;
  logic        core_run;
  logic        fast_clk_en;
  logic        slow_clk_en;
  logic        startup;
  logic        instr_cycle;
  logic        pending;
  logic        irq;
  logic [2:0]  win_rb;
  logic        slow_on = 1'b0;
  int          tick_cnt = 0;
  int          err_count = 0;
  int          num_checks = 0;

  dcpm_power_ctrl dcpm_power_ctrl_i (
    .i_clk_sys              (clk),
    .i_rst_n                (rst_n),
    .i_portg_wr             (portg_wr),
    .i_portg_data           (portg_data),
    .i_halt_disable         (halt_dis),
    .i_wakeup               (wakeup),
    .i_slow_tick            (slow_tick),
    .i_startup_delay_bit    (dly_bit),
    .i_core_clock_select    (ck_sel),
    .i_fast_osc_enable      (fast_en),
    .i_slow_osc_enable      (slow_en),
    .i_dual_clock_enable    (dual_en),
    .i_window_wr            (win_wr),
    .i_idle_window_field    (win_fld),
    .i_idle_tick_irq_enable (irq_en),
    .i_pending_clr          (pnd_clr),
    .o_mode                 (mode),
    .o_halted               (halted),
    .o_idle                 (idle),
    .o_core_run             (core_run),
    .o_fast_clk_en          (fast_clk_en),
    .o_slow_clk_en          (slow_clk_en),
    .o_startup_active       (startup),
    .o_instr_cycle          (instr_cycle),
    .o_idle_tick_pending    (pending),
    .o_idle_tick_irq        (irq),
    .o_idle_window_field    (win_rb)
  );

  always #2 clk = ~clk;

  // Slow clock stand-in: one pulse every second system clock
  always @(negedge clk)
  begin
    if (slow_tick)
      tick_cnt <= tick_cnt + 1;
    slow_tick <= slow_on ? ~slow_tick : 1'b0;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("[ERR] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask

  task automatic summarize();
    $display("checks=%0d mismatches=%0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic wr_g(input logic [7:0] d);
    @(negedge clk);
    portg_wr = 1'b1;
    portg_data = d;
    @(negedge clk);
    portg_wr = 1'b0;
    portg_data = 8'h00;
  endtask

  task automatic pulse_wake();
    @(negedge clk);
    wakeup = 1'b1;
    @(negedge clk);
    wakeup = 1'b0;
  endtask

  task automatic pulse_clr();
    @(negedge clk);
    pnd_clr = 1'b1;
    @(negedge clk);
    pnd_clr = 1'b0;
  endtask

  // Bounded wait; a miss counts as a mismatch
  task automatic wait_hi(ref logic s, input int lim);
    int n;
    n = 0;
    while (s !== 1'b1 && n < lim)
    begin
      @(negedge clk);
      n++;
    end
    chk(s, 1'b1);
  endtask

  task automatic do_reset();
    @(negedge clk);
    rst_n = 1'b0;
    cyc(10);
    chk(mode, 2'b00);
    chk(win_rb, 3'h0);
    chk(core_run, 1'b1);
    rst_n = 1'b1;
    cyc(1);
  endtask

  task automatic t_cycle_and_disable();
    int n;
    n = 0;
    wait_hi(instr_cycle, 10);
    @(negedge clk);
    while (instr_cycle !== 1'b1 && n < 10)
    begin
      @(negedge clk);
      n++;
    end
    chk(n + 1, 5);
    halt_dis = 1'b1;
    wr_g(8'h80);
    cyc(20);
    chk(halted, 1'b0);
    chk(core_run, 1'b1);
    halt_dis = 1'b0;
  endtask

  task automatic t_enter_dual();
    slow_en = 1'b1;
    cyc(4);
    chk(mode, 2'b00);
    dual_en = 1'b1;
    cyc(3);
    chk(mode, 2'b01);
    chk(slow_clk_en, 1'b1);
  endtask

  task automatic t_dual_halt_wake();
    int n;
    n = 0;
    dly_bit = 1'b0;
    wr_g(8'h80);
    wait_hi(halted, 8);
    cyc(2);
    chk(fast_clk_en, 1'b0);
    chk(slow_clk_en, 1'b1);
    chk(core_run, 1'b0);
    pulse_wake();
    chk(halted, 1'b0);
    chk(startup, 1'b1);
    while (startup === 1'b1 && n < 2000)
    begin
      @(negedge clk);
      n++;
    end
    chk((n >= 1276) && (n <= 1284), 1'b1);
    chk(core_run, 1'b1);
    chk(fast_clk_en, 1'b1);
  endtask

  task automatic t_halt_reset();
    dly_bit = 1'b1;
    wr_g(8'h80);
    wait_hi(halted, 8);
    do_reset();
    chk(halted, 1'b0);
    cyc(3);
    chk(mode, 2'b01);
  endtask

  // Measure slow ticks between two pending sets for a window
  task automatic t_window(input logic [2:0] f);
    int t0;
    @(negedge clk);
    win_wr = 1'b1;
    win_fld = f;
    @(negedge clk);
    win_wr = 1'b0;
    chk(win_rb, f);
    pulse_clr();
    wait_hi(pending, 70000);
    t0 = tick_cnt;
    pulse_clr();
    chk(pending, 1'b0);
    wait_hi(pending, 70000);
    chk(tick_cnt - t0, 4096 << f);
    chk(irq, 1'b0);
  endtask

  task automatic t_idle();
    slow_on = 1'b1;
    irq_en = 1'b1;
    pulse_clr();
    chk(pending, 1'b0);
    wr_g(8'h40);
    chk(idle, 1'b1);
    chk(fast_clk_en, 1'b1);
    wait_hi(pending, 17000);
    chk(idle, 1'b0);
    chk(irq, 1'b1);
    chk(core_run, 1'b1);
    irq_en = 1'b0;
    cyc(2);
    chk(irq, 1'b0);
    t_window(3'h0);
    t_window(3'h1);
  endtask

  task automatic t_low_speed();
    ck_sel = 1'b1;
    cyc(2);
    chk(mode, 2'b01);
    fast_en = 1'b0;
    cyc(3);
    chk(mode, 2'b10);
    chk(slow_clk_en, 1'b1);
    wr_g(8'h80);
    wait_hi(halted, 20);
    cyc(3);
    chk(slow_clk_en, 1'b1);
    pulse_wake();
    chk(halted, 1'b0);
    chk(startup, 1'b0);
    chk(core_run, 1'b1);
    chk(mode, 2'b10);
  endtask

  initial
  begin
    // Longest path is the 2x window pair, about 25k clocks
    #(4 * 90000);
    err_count++;
    summarize();
  end

  initial
  begin
    do_reset();
    t_cycle_and_disable();
    t_enter_dual();
    t_dual_halt_wake();
    t_halt_reset();
    t_idle();
    t_low_speed();
    summarize();
  end
endmodule
`default_nettype wire

// [core/dcpm_cycle_div.sv]
// Instruction cycle divider: one tick every DIV system clocks.
// Assumes i_clk_sys stands for the running fast oscillator.
`default_nettype none
module dcpm_cycle_div #(
  parameter int DIV = 5
) (
  input  wire logic i_clk_sys, // Fast oscillator clock
  input  wire logic i_rst_n,   // Async reset, active low
  input  wire logic i_run,     // Oscillator running
  output logic      o_tick,    // Cycle end pulse
  output logic      o_mid      // Mid-cycle pulse
);
  if (DIV < 3)
  begin : g_bad_div
    $error("dcpm_cycle_div: DIV must be at least 3");
  end

  typedef struct packed {
    logic [7:0] cnt;
  } dcpm_div_s;

  dcpm_div_s st_ff;
  dcpm_div_s nxt_st;

  always_comb
  begin
    nxt_st = st_ff;
    if (!i_run)
      nxt_st.cnt = 8'h00;
    else if (st_ff.cnt == 8'(DIV - 1))
      nxt_st.cnt = 8'h00; // see R8
    else
      nxt_st.cnt = st_ff.cnt + 8'h01;
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
      st_ff <= '0;
    else
      st_ff <= nxt_st;
  end

  assign o_tick = i_run && (st_ff.cnt == 8'(DIV - 1));
  assign o_mid  = i_run && (st_ff.cnt == 8'(DIV / 2));
endmodule
`default_nettype wire

// [core/dcpm_idle_timer.sv]
// Idle timer: counts up on slow ticks (cycle ticks in high speed), down during start-up delay.
// Assumes the caller gates ticks off while halted.
`default_nettype none
module dcpm_idle_timer #(
  parameter int W = 17
) (
  input  wire logic         i_clk_sys, // System clock
  input  wire logic         i_rst_n,   // Async reset, active low
  input  wire logic         i_tick,    // Count pulse
  input  wire logic         i_down,    // Count down
  input  wire logic         i_load,    // Load pulse
  input  wire logic [W-1:0] i_load_val,// Value to load
  output logic      [W-1:0] o_count    // Current count
);
  if (W < 10)
  begin : g_bad_w
    $error("dcpm_idle_timer: W too small for delay load");
  end

  typedef struct packed {
    logic [W-1:0] cnt;
  } dcpm_tmr_s;

  dcpm_tmr_s st_ff;
  dcpm_tmr_s nxt_st;

  always_comb
  begin
    nxt_st = st_ff;
    if (i_load)
      nxt_st.cnt = i_load_val;
    else if (i_tick && i_down)
      nxt_st.cnt = st_ff.cnt - W'(1);
    else if (i_tick)
      nxt_st.cnt = st_ff.cnt + W'(1);
  end

  // Count after reset is arbitrary by nature; zero is just cheap
  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
      st_ff <= '0;
    else
      st_ff <= nxt_st;
  end

  assign o_count = st_ff.cnt;
endmodule
`default_nettype wire

// [core/dcpm_power_ctrl.sv]
// Dual clock power-mode controller: HALT, IDLE, clock modes.
// Assumes wake-up detection and clock register bits live outside;
// all inputs are synchronous to i_clk_sys.
`include "dcpm_cfg.svh"
`default_nettype none
module dcpm_power_ctrl #(
  parameter int TMR_W     = `DCPM_TMR_W,
  parameter int INSTR_DIV = `DCPM_INSTR_DIV
) (
  input  wire logic       i_clk_sys,          // 250 MHz clock
  input  wire logic       i_rst_n,            // Async reset, active low
  input  wire logic       i_portg_wr,         // Port G data write pulse
  input  wire logic [7:0] i_portg_data,       // Port G write data
  input  wire logic       i_halt_disable,     // HALT-disable option
  input  wire logic       i_wakeup,           // Enabled wake-up pin event
  input  wire logic       i_slow_tick,        // One pulse per slow clock
  input  wire logic       i_startup_delay_bit,// Delay bit, no effect here
  input  wire logic       i_core_clock_select,// Core on slow clock
  input  wire logic       i_fast_osc_enable,  // Fast oscillator enable
  input  wire logic       i_slow_osc_enable,  // Slow oscillator enable
  input  wire logic       i_dual_clock_enable,// Dual clock enable
  input  wire logic       i_window_wr,        // Window select write
  input  wire logic [2:0] i_idle_window_field,// Window select value
  input  wire logic       i_idle_tick_irq_enable, // Idle interrupt enable
  input  wire logic       i_pending_clr,      // Clear pending pulse
  output logic      [1:0] o_mode,             // Clock mode
  output logic            o_halted,           // In HALT
  output logic            o_idle,             // In IDLE
  output logic            o_core_run,         // Chip clocks enabled
  output logic            o_fast_clk_en,      // Fast oscillator running
  output logic            o_slow_clk_en,      // Slow oscillator running
  output logic            o_startup_active,   // Start-up delay running
  output logic            o_instr_cycle,      // Instruction cycle pulse
  output logic            o_idle_tick_pending,// Idle pending flag
  output logic            o_idle_tick_irq,    // Idle interrupt request
  output logic      [2:0] o_idle_window_field // Window select readback
);
  if (TMR_W < `DCPM_TAP_BASE + `DCPM_WIN_COUNT)
  begin : g_bad_tmr
    $error("dcpm_power_ctrl: TMR_W too narrow for window taps");
  end

  typedef struct packed {
    dcpm_pkg::dcpm_mode_e mode;
    dcpm_pkg::dcpm_pwr_e  pwr;
    logic                 sel_armed;
    logic                 pend;
    logic [2:0]           win;
    logic                 tap_prev;
    logic                 fast_en;
    logic                 slow_en;
    logic                 cyc;
    logic                 irq;
    logic                 halted;
    logic                 idle;
    logic                 core_run;
    logic                 startup;
  } dcpm_ctl_s;

  dcpm_ctl_s st_ff;
  dcpm_ctl_s nxt_st;

  logic             div_run;
  logic             div_tick;
  logic             div_mid;
  logic             cyc_tick;
  logic             cyc_mid;
  logic             tmr_tick;
  logic             tmr_load;
  logic             tmr_down;
  logic [TMR_W-1:0] tmr_count;
  logic             tap;
  logic             tap_toggle;
  logic             halt_req;
  logic             idle_req;
  logic             wake_done;

  // Window field to timer bit; values above the last clamp to 2 s
  function automatic int tap_index(input logic [2:0] win);
    int idx;
    idx = (win > 3'h4) ? 4 : int'(win);
    return `DCPM_TAP_BASE + idx; // see R13
  endfunction

  assign div_run  = (st_ff.mode != dcpm_pkg::MODE_LOW) && (st_ff.pwr != dcpm_pkg::PWR_HALT);
  // Low speed mode runs the core straight off slow ticks
  assign cyc_tick = (st_ff.mode == dcpm_pkg::MODE_LOW) ? i_slow_tick : div_tick;
  assign cyc_mid  = (st_ff.mode == dcpm_pkg::MODE_LOW) ? i_slow_tick : div_mid;

  assign halt_req = i_portg_wr && i_portg_data[`DCPM_HALT_BIT] && !i_halt_disable; // see R1, R10
  assign idle_req = i_portg_wr && i_portg_data[`DCPM_IDLE_BIT]; // see R11

  // Timer source: cycle clock during wake and in high speed, none in HALT, else slow
  always_comb
  begin
    tmr_tick = 1'b0;
    case (st_ff.pwr)
      dcpm_pkg::PWR_WAKE: tmr_tick = div_tick; // see R7
      dcpm_pkg::PWR_HALT: tmr_tick = 1'b0;     // see R3, R22
      default:
        tmr_tick = (st_ff.mode == dcpm_pkg::MODE_HIGH) ? div_tick : i_slow_tick; // see R9, R14
    endcase
  end

  assign tmr_down  = (st_ff.pwr == dcpm_pkg::PWR_WAKE);
  assign tmr_load  = (st_ff.pwr == dcpm_pkg::PWR_HALT) && i_wakeup
                     && (st_ff.mode != dcpm_pkg::MODE_LOW);
  // Done on the 256th decrement
  assign wake_done = tmr_down && div_tick && (tmr_count == TMR_W'(1)); // see R7

  assign tap        = tmr_count[tap_index(st_ff.win)];
  // Compare is skipped around the delay count, which is not real time
  assign tap_toggle = (tap != st_ff.tap_prev) && !tmr_down
                      && (st_ff.pwr != dcpm_pkg::PWR_HALT); // see R15

  dcpm_cycle_div #(
    .DIV (INSTR_DIV)
  ) u_div (
    .i_clk_sys (i_clk_sys),
    .i_rst_n   (i_rst_n),
    .i_run     (div_run),
    .o_tick    (div_tick),
    .o_mid     (div_mid)
  );

  // Timer count is not brought out; only its tap and delay-end decodes reach outputs
  dcpm_idle_timer #(
    .W (TMR_W)
  ) u_tmr (
    .i_clk_sys  (i_clk_sys),
    .i_rst_n    (i_rst_n),
    .i_tick     (tmr_tick),
    .i_down     (tmr_down),
    .i_load     (tmr_load),
    .i_load_val (TMR_W'(`DCPM_STARTUP_LOAD)),
    .o_count    (tmr_count)
  ); // see R18

  always_comb
  begin
    nxt_st          = st_ff;
    nxt_st.tap_prev = tap;
    nxt_st.cyc      = cyc_tick;

    // Set wins over a same-cycle clear
    if (tap_toggle)
      nxt_st.pend = 1'b1; // see R15, R20
    else if (i_pending_clr)
      nxt_st.pend = 1'b0;

    if (i_window_wr)
      nxt_st.win = i_idle_window_field; // see R20

    case (st_ff.pwr)
      dcpm_pkg::PWR_RUN:
      begin
        if (halt_req)
          nxt_st.pwr = dcpm_pkg::PWR_HALT_PEND; // see R1
        else if (idle_req)
          nxt_st.pwr = dcpm_pkg::PWR_IDLE; // see R11
        // Mode bits only act while instructions execute
        case (st_ff.mode)
          dcpm_pkg::MODE_HIGH:
            if (i_slow_osc_enable && i_dual_clock_enable)
              nxt_st.mode = dcpm_pkg::MODE_DUAL; // see R24, R26
          dcpm_pkg::MODE_DUAL:
          begin
            if (i_core_clock_select && i_fast_osc_enable)
              nxt_st.sel_armed = 1'b1;
            if (st_ff.sel_armed && !i_fast_osc_enable)
            begin
              nxt_st.mode      = dcpm_pkg::MODE_LOW; // see R21, R26
              nxt_st.sel_armed = 1'b0;
            end
          end
          dcpm_pkg::MODE_LOW:
            if (i_fast_osc_enable && !i_core_clock_select)
              nxt_st.mode = dcpm_pkg::MODE_DUAL; // see R26
          default:
            nxt_st.mode = dcpm_pkg::MODE_HIGH;
        endcase
      end
      dcpm_pkg::PWR_HALT_PEND:
        if (cyc_mid)
          nxt_st.pwr = dcpm_pkg::PWR_HALT; // see R2
      dcpm_pkg::PWR_HALT:
        if (i_wakeup && st_ff.mode == dcpm_pkg::MODE_LOW)
          nxt_st.pwr = dcpm_pkg::PWR_RUN; // see R4, R25
        else if (i_wakeup)
          nxt_st.pwr = dcpm_pkg::PWR_WAKE; // see R4, R6
      dcpm_pkg::PWR_WAKE:
        if (wake_done)
          nxt_st.pwr = dcpm_pkg::PWR_RUN; // see R7
      dcpm_pkg::PWR_IDLE:
        if (tap_toggle || i_wakeup)
          nxt_st.pwr = dcpm_pkg::PWR_RUN; // see R12, R15
      default:
        nxt_st.pwr = dcpm_pkg::PWR_RUN;
    endcase

    nxt_st.fast_en = (nxt_st.mode != dcpm_pkg::MODE_LOW)
                     && (nxt_st.pwr != dcpm_pkg::PWR_HALT); // see R3
    nxt_st.slow_en = (nxt_st.mode != dcpm_pkg::MODE_HIGH) || i_slow_osc_enable; // see R22
    // Core finishes its instruction, then takes the vector
    nxt_st.irq     = nxt_st.pend && i_idle_tick_irq_enable; // see R16, R19
    // Status outputs come from flops; decoded one state ahead
    nxt_st.halted   = (nxt_st.pwr == dcpm_pkg::PWR_HALT);
    nxt_st.idle     = (nxt_st.pwr == dcpm_pkg::PWR_IDLE);
    nxt_st.core_run = (nxt_st.pwr == dcpm_pkg::PWR_RUN)
                      || (nxt_st.pwr == dcpm_pkg::PWR_HALT_PEND);
    nxt_st.startup  = (nxt_st.pwr == dcpm_pkg::PWR_WAKE);
  end

  // Reset puts every mode back to high speed
  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      st_ff          <= '0;
      st_ff.mode     <= dcpm_pkg::MODE_HIGH; // see R5
      st_ff.pwr      <= dcpm_pkg::PWR_RUN;
      st_ff.win      <= `DCPM_WIN_RESET; // see R23
      st_ff.fast_en  <= 1'b1;
      st_ff.core_run <= 1'b1;
    end
    else
      st_ff <= nxt_st;
  end

  assign o_mode              = st_ff.mode;
  assign o_halted            = st_ff.halted;
  assign o_idle              = st_ff.idle;
  assign o_core_run          = st_ff.core_run;
  assign o_fast_clk_en       = st_ff.fast_en;
  assign o_slow_clk_en       = st_ff.slow_en;
  assign o_startup_active    = st_ff.startup;
  assign o_instr_cycle       = st_ff.cyc;
  assign o_idle_tick_pending = st_ff.pend;
  assign o_idle_tick_irq     = st_ff.irq;
  assign o_idle_window_field = st_ff.win;

  // Helper: instruction cycles spent in the start-up delay
  logic [9:0] dly_cnt_ff;
  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
      dly_cnt_ff <= 10'h000;
    else if (st_ff.pwr != dcpm_pkg::PWR_WAKE)
      dly_cnt_ff <= 10'h000;
    else if (div_tick)
      dly_cnt_ff <= dly_cnt_ff + 10'h001;
  end

  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_rst_n);

  sequence s_halt_request;
    st_ff.pwr == dcpm_pkg::PWR_RUN && halt_req;
  endsequence

  sequence s_dual_wake;
    st_ff.pwr == dcpm_pkg::PWR_HALT && i_wakeup && st_ff.mode != dcpm_pkg::MODE_LOW;
  endsequence

  chk_halt_entry: assert property ( // see R1
      s_halt_request |=> st_ff.pwr == dcpm_pkg::PWR_HALT_PEND)
    else $error("halt request not taken");
  chk_halt_disabled: assert property ( // see R10
      st_ff.pwr == dcpm_pkg::PWR_RUN && i_portg_wr && i_portg_data[`DCPM_HALT_BIT]
      && i_halt_disable |=> st_ff.pwr != dcpm_pkg::PWR_HALT_PEND)
    else $error("halt entered while disabled");
  // A wake-up may follow at once, so only the first HALT cycle is judged
  chk_halt_freeze: assert property ( // see R2
      st_ff.pwr == dcpm_pkg::PWR_HALT_PEND && cyc_mid
      |=> st_ff.pwr == dcpm_pkg::PWR_HALT && !o_core_run)
    else $error("halt not frozen mid cycle");
  chk_halt_clocks: assert property ( // see R3
      o_halted && st_ff.mode == dcpm_pkg::MODE_DUAL && $past(o_halted)
      |-> !o_fast_clk_en && o_slow_clk_en && $stable(tmr_count))
    else $error("dual halt clocks wrong");
  chk_wake_delay: assert property ( // see R6
      s_dual_wake |=> o_startup_active ##1 (o_startup_active && !o_core_run)[*4])
    else $error("wake without start-up delay");
  chk_delay_length: assert property ( // see R7
      $fell(o_startup_active) |-> dly_cnt_ff == 10'd256)
    else $error("start-up delay not 256 cycles");
  chk_low_wake: assert property ( // see R25
      o_halted && i_wakeup && st_ff.mode == dcpm_pkg::MODE_LOW |=> o_core_run)
    else $error("low speed wake delayed");
  chk_div_five: assert property (div_tick |=> !div_tick [*4]) // see R8
    else $error("instruction cycle shorter than five clocks");
  chk_idle_entry: assert property ( // see R11
      st_ff.pwr == dcpm_pkg::PWR_RUN && idle_req && !halt_req |=> o_idle)
    else $error("idle request not taken");
  chk_pend_set: assert property (tap_toggle |=> o_idle_tick_pending) // see R15
    else $error("window toggle missed");
  // An IDLE request in the toggle cycle itself waits for the next toggle
  chk_idle_exit: assert property (o_idle && tap_toggle |=> !o_idle) // see R15
    else $error("idle not left on window toggle");
  chk_irq_gate: assert property (!i_idle_tick_irq_enable |=> !o_idle_tick_irq) // see R19
    else $error("interrupt without enable");
  chk_low_entry: assert property ( // see R21
      st_ff.mode == dcpm_pkg::MODE_DUAL && !st_ff.sel_armed
      |=> st_ff.mode != dcpm_pkg::MODE_LOW)
    else $error("low speed entered out of order");
endmodule
`default_nettype wire

// [shared/dcpm_cfg.svh]
// Offsets, bit positions, reset values and timing counts for the
// dual clock power-mode controller. Included by the dcpm_power_ctrl module.
// Function
// R1: Port G bit 7 write enters HALT
// R2: HALT freezes midway through next cycle
// R3: Dual HALT: fast clock off, timer unclocked
// R4: Reset or enabled wake-up pin leaves HALT
// R5: Reset from dual HALT returns high speed
// R6: Dual HALT wake always inserts start-up delay
// R7: Delay loads 256, counts down per cycle
// R8: Instruction cycle is fast oscillator over five
// R9: After delay timer returns to slow clock
// R10: HALT-disable option ignores HALT requests
// R11: Port G bit 6 write enters IDLE
// R12: Dual IDLE keeps clocks, timer on slow
// R13: Five windows, eighth second to two seconds
// R14: Timer runs from slow clock continuously; code uses cycle clock in high speed and delay, none in HALT
// R15: Window bit toggle sets pending, exits IDLE
// R16: Idle exit completes instruction, then interrupt
// R17: Software clears pending before requesting IDLE
// R18: Timer hidden from software, reset count arbitrary
// R19: Interrupt only while enable bit set
// R20: Window change may set pending spuriously
// R21: Low speed entry: select, then fast off
// R22: Low speed HALT: slow osc on, timer stopped
// R23: Reset clears window select to shortest
// R24: Dual entry: slow osc on, then enable
// R25: Low speed HALT wake has no delay
// R26: Explicit clock mode state register
`ifndef DCPM_CFG_SVH
`define DCPM_CFG_SVH
`define DCPM_HALT_BIT     7
`define DCPM_IDLE_BIT     6
`define DCPM_STARTUP_LOAD 256
`define DCPM_INSTR_DIV    5
`define DCPM_SLOW_HZ      32768
`define DCPM_WIN0_MS      125
`define DCPM_WIN0_TICKS   (`DCPM_WIN0_MS * `DCPM_SLOW_HZ / 1000)
`define DCPM_TAP_BASE     12
`define DCPM_WIN_COUNT    5
`define DCPM_WIN_RESET    3'h0
`define DCPM_TMR_W        17
`endif

// [shared/dcpm_pkg.sv]
// Types for the dual clock power-mode controller.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none
package dcpm_pkg;
  typedef enum logic [1:0] {
    MODE_HIGH = 2'b00,
    MODE_DUAL = 2'b01,
    MODE_LOW  = 2'b10
  } dcpm_mode_e;

  typedef enum logic [2:0] {
    PWR_RUN       = 3'b000,
    PWR_HALT_PEND = 3'b001,
    PWR_HALT      = 3'b010,
    PWR_WAKE      = 3'b011,
    PWR_IDLE      = 3'b100
  } dcpm_pwr_e;
endpackage
`default_nettype wire
